// *** src/ppfm_port_mux.sv ***
// Pin function multiplexer for ports A to E with an APB register file.
// Assumes peripherals run on pclk; pad levels arrive asynchronously.
//
// Contract
// - Every pin is plain bidirectional I/O unless a function is chosen.
// - Each port A pin selects keypad input or analog channel.
// - Each port B pin may serve as an analog channel.
// - Ports A, C and D offer selectable pullups on input pins.
// - A pullup is disconnected while its pin drives as output.
// - Pullup selection is independent for every bit.
// - Low four port D pins carry SPI signals, select on pin 0.
// - Each high port D pin may carry a channel of either timer.
// - Lowest port D pin may drive out an internal clock.
// - Port E bit 1 is serial receive, bit 0 serial transmit.
//
// Our own choices: the address map and the APB register port.

module ppfm_port_mux #(
  parameter int unsigned A_W = 8,
  parameter int unsigned B_W = 8,
  parameter int unsigned C_W = 7,
  parameter int unsigned D_W = 8,
  parameter int unsigned E_W = 6
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [A_W-1:0] port_a_pins_in,
  output logic      [A_W-1:0] port_a_pins_out,
  output logic      [A_W-1:0] port_a_pins_oe_n,
  output logic      [A_W-1:0] port_a_pullup,
  input  wire logic [B_W-1:0] port_b_pins_in,
  output logic      [B_W-1:0] port_b_pins_out,
  output logic      [B_W-1:0] port_b_pins_oe_n,
  input  wire logic [C_W-1:0] port_c_pins_in,
  output logic      [C_W-1:0] port_c_pins_out,
  output logic      [C_W-1:0] port_c_pins_oe_n,
  output logic      [C_W-1:0] port_c_pullup,
  input  wire logic [D_W-1:0] port_d_pins_in,
  output logic      [D_W-1:0] port_d_pins_out,
  output logic      [D_W-1:0] port_d_pins_oe_n,
  output logic      [D_W-1:0] port_d_pullup,
  input  wire logic [E_W-1:0] port_e_pins_in,
  output logic      [E_W-1:0] port_e_pins_out,
  output logic      [E_W-1:0] port_e_pins_oe_n,
  output logic      [7:0]  keypad_irq_in,
  output logic      [15:0] analog_chan_en,
  output logic      [3:0]  spi_in,
  input  wire logic [3:0]  spi_out,
  input  wire logic [3:0]  spi_oe,
  output logic      [3:0]  first_timer_in,
  input  wire logic [3:0]  first_timer_out,
  input  wire logic [3:0]  first_timer_oe,
  output logic      [3:0]  second_timer_in,
  input  wire logic [3:0]  second_timer_out,
  input  wire logic [3:0]  second_timer_oe,
  input  wire logic        clock_out_src,
  output logic             async_serial_rx,
  input  wire logic        async_serial_tx
);

  // ************************************************************
  // Registers
  // ************************************************************
  logic [A_W-1:0] a_dat_r, a_dir_r, a_pull_r;
  logic [B_W-1:0] b_dat_r, b_dir_r;
  logic [C_W-1:0] c_dat_r, c_dir_r, c_pull_r;
  logic [D_W-1:0] d_dat_r, d_dir_r, d_pull_r;
  logic [E_W-1:0] e_dat_r, e_dir_r;
  logic [7:0]     a_kbd_r, a_adc_r, b_adc_r;
  logic [3:0]     d_tim_en_r, d_tim_unit_r;
  logic           d_spi_en_r, d_clk_en_r, e_ser_en_r;
  logic [31:0]    prdata_r, rd_nxt;
  logic           pslverr_r, err_nxt;
  logic           wr_lo, wr_hi;

  logic [A_W-1:0] pa_sync;
  logic [B_W-1:0] pb_sync;
  logic [C_W-1:0] pc_sync;
  logic [D_W-1:0] pd_sync;
  logic [E_W-1:0] pe_sync;

  // Byte lanes: low lane for most fields, lane one for upper fields
  assign wr_lo = psel & penable & pwrite & pstrb[0];
  assign wr_hi = psel & penable & pwrite & pstrb[1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_dat_r <= A_W'(ppfm_pkg::RST_REG);
      b_dat_r <= B_W'(ppfm_pkg::RST_REG);
      c_dat_r <= C_W'(ppfm_pkg::RST_REG);
      d_dat_r <= D_W'(ppfm_pkg::RST_REG);
      e_dat_r <= E_W'(ppfm_pkg::RST_REG);
    end else if (wr_lo) begin
      case (paddr)
        ppfm_pkg::A_DATA: a_dat_r <= pwdata[A_W-1:0];
        ppfm_pkg::B_DATA: b_dat_r <= pwdata[B_W-1:0];
        ppfm_pkg::C_DATA: c_dat_r <= pwdata[C_W-1:0];
        ppfm_pkg::D_DATA: d_dat_r <= pwdata[D_W-1:0];
        ppfm_pkg::E_DATA: e_dat_r <= pwdata[E_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_dir_r <= A_W'(ppfm_pkg::RST_REG);
      b_dir_r <= B_W'(ppfm_pkg::RST_REG);
      c_dir_r <= C_W'(ppfm_pkg::RST_REG);
      d_dir_r <= D_W'(ppfm_pkg::RST_REG);
      e_dir_r <= E_W'(ppfm_pkg::RST_REG);
    end else if (wr_lo) begin
      case (paddr)
        ppfm_pkg::A_DIR: a_dir_r <= pwdata[A_W-1:0];
        ppfm_pkg::B_DIR: b_dir_r <= pwdata[B_W-1:0];
        ppfm_pkg::C_DIR: c_dir_r <= pwdata[C_W-1:0];
        ppfm_pkg::D_DIR: d_dir_r <= pwdata[D_W-1:0];
        ppfm_pkg::E_DIR: e_dir_r <= pwdata[E_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_pull_r <= A_W'(ppfm_pkg::RST_REG);
      c_pull_r <= C_W'(ppfm_pkg::RST_REG);
      d_pull_r <= D_W'(ppfm_pkg::RST_REG);
    end else if (wr_lo) begin
      case (paddr)
        ppfm_pkg::A_PULL: a_pull_r <= pwdata[A_W-1:0];
        ppfm_pkg::C_PULL: c_pull_r <= pwdata[C_W-1:0];
        ppfm_pkg::D_PULL: d_pull_r <= pwdata[D_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_kbd_r      <= ppfm_pkg::RST_REG;
      a_adc_r      <= ppfm_pkg::RST_REG;
      b_adc_r      <= ppfm_pkg::RST_REG;
      d_tim_en_r   <= ppfm_pkg::RST_REG[3:0];
      d_tim_unit_r <= ppfm_pkg::RST_REG[3:0];
      d_spi_en_r   <= 1'b0;
      d_clk_en_r   <= 1'b0;
      e_ser_en_r   <= 1'b0;
    end else begin
      if (wr_lo && paddr == ppfm_pkg::FUNC_A)
        a_kbd_r <= pwdata[ppfm_pkg::KBD_LSB +: 8];
      if (wr_hi && paddr == ppfm_pkg::FUNC_A)
        a_adc_r <= pwdata[ppfm_pkg::ADC_LSB +: 8];
      if (wr_lo && paddr == ppfm_pkg::FUNC_B)
        b_adc_r <= pwdata[7:0];
      if (wr_lo && paddr == ppfm_pkg::FUNC_D) begin
        d_tim_en_r   <= pwdata[ppfm_pkg::TIM_EN_LSB +: 4];
        d_tim_unit_r <= pwdata[ppfm_pkg::TIM_UNIT_LSB +: 4];
      end
      if (wr_hi && paddr == ppfm_pkg::FUNC_D) begin
        d_spi_en_r <= pwdata[ppfm_pkg::SPI_EN_BIT];
        d_clk_en_r <= pwdata[ppfm_pkg::CLK_EN_BIT];
      end
      if (wr_lo && paddr == ppfm_pkg::FUNC_E)
        e_ser_en_r <= pwdata[ppfm_pkg::SER_EN_BIT];
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  // Output pins read their latch, input pins the synced pad level
  function automatic logic [31:0] mix(input logic [7:0] lat,
                                      input logic [7:0] dir,
                                      input logic [7:0] pin);
    return {24'h000000, (lat & dir) | (pin & ~dir)};
  endfunction

  always_comb begin
    rd_nxt  = 32'h00000000;
    err_nxt = 1'b0;
    case (paddr)
      ppfm_pkg::A_DATA: rd_nxt = mix(8'(a_dat_r), 8'(a_dir_r), 8'(pa_sync));
      ppfm_pkg::B_DATA: rd_nxt = mix(8'(b_dat_r), 8'(b_dir_r), 8'(pb_sync));
      ppfm_pkg::C_DATA: rd_nxt = mix(8'(c_dat_r), 8'(c_dir_r), 8'(pc_sync));
      ppfm_pkg::D_DATA: rd_nxt = mix(8'(d_dat_r), 8'(d_dir_r), 8'(pd_sync));
      ppfm_pkg::E_DATA: rd_nxt = mix(8'(e_dat_r), 8'(e_dir_r), 8'(pe_sync));
      ppfm_pkg::A_DIR:  rd_nxt = 32'(a_dir_r);
      ppfm_pkg::B_DIR:  rd_nxt = 32'(b_dir_r);
      ppfm_pkg::C_DIR:  rd_nxt = 32'(c_dir_r);
      ppfm_pkg::D_DIR:  rd_nxt = 32'(d_dir_r);
      ppfm_pkg::E_DIR:  rd_nxt = 32'(e_dir_r);
      ppfm_pkg::A_PULL: rd_nxt = 32'(a_pull_r);
      ppfm_pkg::C_PULL: rd_nxt = 32'(c_pull_r);
      ppfm_pkg::D_PULL: rd_nxt = 32'(d_pull_r);
      ppfm_pkg::FUNC_A: rd_nxt = 32'({a_adc_r, a_kbd_r});
      ppfm_pkg::FUNC_B: rd_nxt = 32'(b_adc_r);
      ppfm_pkg::FUNC_D: rd_nxt = 32'({d_clk_en_r, d_spi_en_r,
                                      d_tim_unit_r, d_tim_en_r});
      ppfm_pkg::FUNC_E: rd_nxt = 32'(e_ser_en_r);
      default:          err_nxt = 1'b1;
    endcase
  end

  // Captured in setup so prdata comes from a flop with zero wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else if (psel && !penable) begin
      prdata_r  <= pwrite ? 32'h00000000 : rd_nxt;
      pslverr_r <= err_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;
  assign pready  = 1'b1;

  // ************************************************************
  // Pad synchronisers
  // ************************************************************
  ppfm_sync #(
    .W(A_W + B_W + C_W + D_W + E_W)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({port_a_pins_in, port_b_pins_in, port_c_pins_in,
                port_d_pins_in, port_e_pins_in}),
    .q       ({pa_sync, pb_sync, pc_sync, pd_sync, pe_sync})
  );

  // ************************************************************
  // Alternate function routing
  // ************************************************************
  logic [7:0]     a_kbd_eff;
  logic [D_W-1:0] d_alt_en, d_alt_out, d_alt_oe;
  logic [E_W-1:0] e_alt_en, e_alt_out, e_alt_oe;
  logic [3:0]     tim_out, tim_oe;

  // analog wins over keypad on one pin
  assign a_kbd_eff     = a_kbd_r & ~a_adc_r;
  assign keypad_irq_in = (a_kbd_eff & 8'(pa_sync)) | ~a_kbd_eff;
  assign analog_chan_en = {a_adc_r, b_adc_r};

  assign tim_out = (d_tim_unit_r & second_timer_out) |
                   (~d_tim_unit_r & first_timer_out);
  assign tim_oe  = (d_tim_unit_r & second_timer_oe) |
                   (~d_tim_unit_r & first_timer_oe);
  assign first_timer_in  = pd_sync[ppfm_pkg::TIM_PIN0 +: ppfm_pkg::TIM_N];
  assign second_timer_in = pd_sync[ppfm_pkg::TIM_PIN0 +: ppfm_pkg::TIM_N];
  assign spi_in = pd_sync[ppfm_pkg::SPI_N-1:0];

  always_comb begin
    d_alt_en  = '0;
    d_alt_out = '0;
    d_alt_oe  = '0;
    d_alt_en[ppfm_pkg::TIM_PIN0 +: ppfm_pkg::TIM_N]  = d_tim_en_r;
    d_alt_out[ppfm_pkg::TIM_PIN0 +: ppfm_pkg::TIM_N] = tim_out;
    d_alt_oe[ppfm_pkg::TIM_PIN0 +: ppfm_pkg::TIM_N]  = tim_oe;
    d_alt_en[ppfm_pkg::SPI_N-1:0]  = {ppfm_pkg::SPI_N{d_spi_en_r}};
    d_alt_out[ppfm_pkg::SPI_N-1:0] = spi_out;
    d_alt_oe[ppfm_pkg::SPI_N-1:0]  = spi_oe;
    if (d_clk_en_r) begin
      d_alt_en[ppfm_pkg::CLK_PIN]  = 1'b1;
      d_alt_out[ppfm_pkg::CLK_PIN] = clock_out_src;
      d_alt_oe[ppfm_pkg::CLK_PIN]  = 1'b1;
    end
  end

  always_comb begin
    e_alt_en  = '0;
    e_alt_out = '0;
    e_alt_oe  = '0;
    e_alt_en[ppfm_pkg::RX_PIN]  = e_ser_en_r;
    e_alt_en[ppfm_pkg::TX_PIN]  = e_ser_en_r;
    e_alt_out[ppfm_pkg::TX_PIN] = async_serial_tx;
    e_alt_oe[ppfm_pkg::TX_PIN]  = 1'b1;
  end
  // Idle high so a disabled receiver sees a stop level
  assign async_serial_rx = e_ser_en_r ? pe_sync[ppfm_pkg::RX_PIN] : 1'b1;

  // ************************************************************
  // Pad cells
  // ************************************************************
  // pullups on ports A, C and D
  ppfm_pin_cell #(.W(A_W), .HAS_PULL(1'b1)) u_cell_a (
    .pclk      (pclk),
    .presetn   (presetn),
    .gpio_dout (a_dat_r),
    .gpio_dir  (a_dir_r),
    .pull_sel  (a_pull_r),
    .alt_en    ('0),
    .alt_out   ('0),
    .alt_oe    ('0),
    .ana_en    (A_W'(a_adc_r)),
    .pin_out   (port_a_pins_out),
    .pin_oe_n  (port_a_pins_oe_n),
    .pull_on   (port_a_pullup)
  );

  ppfm_pin_cell #(.W(B_W), .HAS_PULL(1'b0)) u_cell_b (
    .pclk      (pclk),
    .presetn   (presetn),
    .gpio_dout (b_dat_r),
    .gpio_dir  (b_dir_r),
    .pull_sel  ('0),
    .alt_en    ('0),
    .alt_out   ('0),
    .alt_oe    ('0),
    .ana_en    (B_W'(b_adc_r)),
    .pin_out   (port_b_pins_out),
    .pin_oe_n  (port_b_pins_oe_n),
    .pull_on   ()
  );

  ppfm_pin_cell #(.W(C_W), .HAS_PULL(1'b1)) u_cell_c (
    .pclk      (pclk),
    .presetn   (presetn),
    .gpio_dout (c_dat_r),
    .gpio_dir  (c_dir_r),
    .pull_sel  (c_pull_r),
    .alt_en    ('0),
    .alt_out   ('0),
    .alt_oe    ('0),
    .ana_en    ('0),
    .pin_out   (port_c_pins_out),
    .pin_oe_n  (port_c_pins_oe_n),
    .pull_on   (port_c_pullup)
  );

  ppfm_pin_cell #(.W(D_W), .HAS_PULL(1'b1)) u_cell_d (
    .pclk      (pclk),
    .presetn   (presetn),
    .gpio_dout (d_dat_r),
    .gpio_dir  (d_dir_r),
    .pull_sel  (d_pull_r),
    .alt_en    (d_alt_en),
    .alt_out   (d_alt_out),
    .alt_oe    (d_alt_oe),
    .ana_en    ('0),
    .pin_out   (port_d_pins_out),
    .pin_oe_n  (port_d_pins_oe_n),
    .pull_on   (port_d_pullup)
  );

  ppfm_pin_cell #(.W(E_W), .HAS_PULL(1'b0)) u_cell_e (
    .pclk      (pclk),
    .presetn   (presetn),
    .gpio_dout (e_dat_r),
    .gpio_dir  (e_dir_r),
    .pull_sel  ('0),
    .alt_en    (e_alt_en),
    .alt_out   (e_alt_out),
    .alt_oe    (e_alt_oe),
    .ana_en    ('0),
    .pin_out   (port_e_pins_out),
    .pin_oe_n  (port_e_pins_oe_n),
    .pull_on   ()
  );

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_gpio_follow_dir:
    assert property (!d_spi_en_r && !d_clk_en_r && d_tim_en_r == 4'h0
      |=> port_d_pins_oe_n == ~$past(d_dir_r)
          && port_d_pins_out == $past(d_dat_r))
    else $error("port D not plain I/O");
  chk_adc_a_input:
    assert property (1'b1 |=> (8'(port_a_pins_oe_n) & $past(a_adc_r))
      == $past(a_adc_r) && (8'(port_a_pullup) & $past(a_adc_r)) == 8'h00)
    else $error("analog pin on port A not released");
  chk_keypad_pass:
    assert property (a_kbd_eff[0] |-> keypad_irq_in[0] == pa_sync[0])
    else $error("keypad input not passed through");
  chk_adc_b_input:
    assert property (1'b1 |=>
      (8'(port_b_pins_oe_n) & $past(b_adc_r)) == $past(b_adc_r))
    else $error("analog pin on port B driven");
  chk_pull_input:
    assert property (1'b1 |=> port_c_pullup ==
      ($past(c_pull_r) & ~$past(c_dir_r)))
    else $error("port C pullup wrong");
  chk_spi_drive:
    assert property (d_spi_en_r && !d_clk_en_r |=>
      port_d_pins_out[3:0] == $past(spi_out)
      && port_d_pins_oe_n[3:0] == ~$past(spi_oe))
    else $error("SPI pins not owned by SPI");
  chk_timer_select:
    assert property (d_tim_en_r[0] && d_tim_unit_r[0] |=>
      port_d_pins_out[4] == $past(second_timer_out[0]))
    else $error("timer unit select wrong");
  chk_clock_out:
    assert property (d_clk_en_r |=> !port_d_pins_oe_n[0]
      && port_d_pins_out[0] == $past(clock_out_src))
    else $error("clock not driven on port D pin 0");
  chk_serial_pins:
    assert property (e_ser_en_r |=> !port_e_pins_oe_n[0]
      && port_e_pins_oe_n[1] && port_e_pins_out[0] == $past(async_serial_tx))
    else $error("serial pins wrong");
  chk_reset_state:
    assert property ($rose(presetn) |-> &port_a_pins_oe_n
      && &port_d_pins_oe_n && port_a_pullup == '0 && port_d_pullup == '0)
    else $error("pins not inputs after reset");

  cov_spi_on: cover property (d_spi_en_r && spi_oe[1]);
  cov_clk_out: cover property (d_clk_en_r ##1 d_clk_en_r);
  cov_serial: cover property (e_ser_en_r && !async_serial_rx);
  cov_adc_a: cover property (a_adc_r != 8'h00 && a_kbd_r != 8'h00);

endmodule

// *** src/ppfm_pkg.sv ***
// Constants shared by the port pin function multiplexer.
// Assumes a 32-bit APB slave with byte addresses and one word per register.

package ppfm_pkg;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] A_DATA = 8'h00;
  localparam logic [7:0] A_DIR  = 8'h04;
  localparam logic [7:0] A_PULL = 8'h08;
  localparam logic [7:0] B_DATA = 8'h0c;
  localparam logic [7:0] B_DIR  = 8'h10;
  localparam logic [7:0] C_DATA = 8'h14;
  localparam logic [7:0] C_DIR  = 8'h18;
  localparam logic [7:0] C_PULL = 8'h1c;
  localparam logic [7:0] D_DATA = 8'h20;
  localparam logic [7:0] D_DIR  = 8'h24;
  localparam logic [7:0] D_PULL = 8'h28;
  localparam logic [7:0] E_DATA = 8'h2c;
  localparam logic [7:0] E_DIR  = 8'h30;
  localparam logic [7:0] FUNC_A = 8'h34;
  localparam logic [7:0] FUNC_B = 8'h38;
  localparam logic [7:0] FUNC_D = 8'h3c;
  localparam logic [7:0] FUNC_E = 8'h40;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int unsigned KBD_LSB      = 0;
  localparam int unsigned ADC_LSB      = 8;
  localparam int unsigned TIM_EN_LSB   = 0;
  localparam int unsigned TIM_UNIT_LSB = 4;
  localparam int unsigned SPI_EN_BIT   = 8;
  localparam int unsigned CLK_EN_BIT   = 9;
  localparam int unsigned SER_EN_BIT   = 0;

  // ************************************************************
  // Pin assignments and reset values
  // ************************************************************
  localparam int unsigned SPI_N    = 4;
  localparam int unsigned TIM_N    = 4;
  localparam int unsigned TIM_PIN0 = 4;
  localparam int unsigned CLK_PIN  = 0;
  localparam int unsigned TX_PIN   = 0;
  localparam int unsigned RX_PIN   = 1;
  localparam logic [7:0]  RST_REG  = 8'h00;

endpackage

// *** src/ppfm_sync.sv ***
// Two-stage synchroniser for pin levels.
// Assumes inputs are asynchronous levels, not pulses.

module ppfm_sync #(
  parameter int unsigned W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // First stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

  assign q = q_r;

endmodule

// *** src/ppfm_pin_cell.sv ***
// One port's pad control: direction, value and pullup per pin.
// Assumes alternate function inputs come from logic on pclk.

module ppfm_pin_cell #(
  parameter int unsigned W        = 8,
  parameter bit          HAS_PULL = 1'b1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] gpio_dout,
  input  wire logic [W-1:0] gpio_dir,
  input  wire logic [W-1:0] pull_sel,
  input  wire logic [W-1:0] alt_en,
  input  wire logic [W-1:0] alt_out,
  input  wire logic [W-1:0] alt_oe,
  input  wire logic [W-1:0] ana_en,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe_n,
  output logic      [W-1:0] pull_on
);

  logic [W-1:0] drive_nxt;
  logic [W-1:0] out_nxt;
  logic [W-1:0] pull_nxt;
  logic [W-1:0] out_r;
  logic [W-1:0] oe_n_r;
  logic [W-1:0] pull_r;

  always_comb begin
    drive_nxt = ~ana_en & ((alt_en & alt_oe) | (~alt_en & gpio_dir));
    out_nxt   = (alt_en & alt_out) | (~alt_en & gpio_dout);
    pull_nxt  = HAS_PULL ? (pull_sel & ~drive_nxt & ~ana_en) : '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r  <= '0;
      oe_n_r <= '1;
      pull_r <= '0;
    end else begin
      out_r  <= out_nxt;
      oe_n_r <= ~drive_nxt;
      pull_r <= pull_nxt;
    end
  end

  assign pin_out  = out_r;
  assign pin_oe_n = oe_n_r;
  assign pull_on  = pull_r;

  chk_pull_gate:
    assert property (@(posedge pclk) disable iff (!presetn)
      (pull_r & ~oe_n_r) == '0)
    else $error("pullup on while pin driven");

endmodule

// *** verif/ppfm_board_model.sv ***
// Board and pad model that closes the loop of every port pin.
// Assumes the bench gives weak board levels; a pullup wins over them.
module ppfm_board_model (
  input  wire logic [7:0] port_a_pins_out,
  input  wire logic [7:0] port_a_pins_oe_n,
  input  wire logic [7:0] port_a_pullup,
  input  wire logic [7:0] ext_a,
  output logic      [7:0] port_a_pins_in,
  input  wire logic [7:0] port_b_pins_out,
  input  wire logic [7:0] port_b_pins_oe_n,
  input  wire logic [7:0] ext_b,
  output logic      [7:0] port_b_pins_in,
  input  wire logic [6:0] port_c_pins_out,
  input  wire logic [6:0] port_c_pins_oe_n,
  input  wire logic [6:0] port_c_pullup,
  input  wire logic [6:0] ext_c,
  output logic      [6:0] port_c_pins_in,
  input  wire logic [7:0] port_d_pins_out,
  input  wire logic [7:0] port_d_pins_oe_n,
  input  wire logic [7:0] port_d_pullup,
  input  wire logic [7:0] ext_d,
  output logic      [7:0] port_d_pins_in,
  input  wire logic [5:0] port_e_pins_out,
  input  wire logic [5:0] port_e_pins_oe_n,
  input  wire logic [5:0] ext_e,
  output logic      [5:0] port_e_pins_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Driven pad shows its own value, else pullup or board
  assign port_a_pins_in = ~port_a_pins_oe_n & port_a_pins_out
                        | port_a_pins_oe_n & (port_a_pullup | ext_a);
  assign port_b_pins_in = ~port_b_pins_oe_n & port_b_pins_out
                        | port_b_pins_oe_n & ext_b;
  assign port_c_pins_in = ~port_c_pins_oe_n & port_c_pins_out
                        | port_c_pins_oe_n & (port_c_pullup | ext_c);
  assign port_d_pins_in = ~port_d_pins_oe_n & port_d_pins_out
                        | port_d_pins_oe_n & (port_d_pullup | ext_d);
  assign port_e_pins_in = ~port_e_pins_oe_n & port_e_pins_out
                        | port_e_pins_oe_n & ext_e;
endmodule

// *** verif/test_ppfm_port_mux.sv ***
// Self-checking bench for the port pin function multiplexer.
// Assumes zero-wait APB and the board model on every pad.
module test_ppfm_port_mux;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, erv;
  logic [7:0]  paddr, dr, ks, an, tm, keypad_irq_in;
  logic [31:0] pwdata, prdata, prv;
  logic [3:0]  pstrb, spi_in, spi_out, spi_oe;
  logic [7:0]  port_a_pins_in, port_a_pins_out, port_a_pins_oe_n;
  logic [7:0]  port_a_pullup, ext_a, ext_b, ext_d;
  logic [7:0]  port_b_pins_in, port_b_pins_out, port_b_pins_oe_n;
  logic [6:0]  port_c_pins_in, port_c_pins_out, port_c_pins_oe_n;
  logic [6:0]  port_c_pullup, ext_c;
  logic [7:0]  port_d_pins_in, port_d_pins_out, port_d_pins_oe_n;
  logic [7:0]  port_d_pullup;
  logic [5:0]  port_e_pins_in, port_e_pins_out, port_e_pins_oe_n, ext_e;
  logic [15:0] analog_chan_en;
  logic [3:0]  first_timer_in, first_timer_out, first_timer_oe;
  logic [3:0]  second_timer_in, second_timer_out, second_timer_oe;
  logic        clock_out_src, async_serial_rx, async_serial_tx;
  logic [31:0] mdl [17];
  int          miscompares, n_compared;

  ppfm_port_mux DUT (.*);
  ppfm_board_model board (.*);

  // ************
  // Tasks
  // ************
  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp32({24'h0, g}, {24'h0, e});
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    prv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    // Only the implemented field bits read back
    mdl[a[7:2]] = d & (a == ppfm_pkg::FUNC_A ? 32'hffff :
                       a == ppfm_pkg::FUNC_D ? 32'h3ff :
                       a == ppfm_pkg::FUNC_E ? 32'h1 : 32'hff);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    cmp32(prv, mdl[a[7:2]]);
    cmp32({31'h0, erv}, 32'h0);
  endtask
  task automatic pause();
    repeat (4) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic end_of_test();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ************
  // Sequence
  // ************
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    #2000000;
    miscompares++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h7cb5));
    {presetn, psel, penable, pwrite, clock_out_src, async_serial_tx} = '0;
    {paddr, pwdata, ext_a, ext_b, ext_c, ext_d, ext_e, spi_out} = '0;
    {spi_oe, first_timer_out, first_timer_oe} = '0;
    {second_timer_out, second_timer_oe} = '0;
    pstrb = 4'hf;
    mdl = '{default: 32'h0};
    n_compared = 0;
    miscompares = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(port_a_pins_oe_n & port_b_pins_oe_n & port_d_pins_oe_n, 8'hff);
    chk({port_c_pins_oe_n, 1'b1} & {2'b11, port_e_pins_oe_n}, 8'hff);
    chk(port_a_pullup | port_d_pullup | {1'b0, port_c_pullup}, 8'h0);
    chk(keypad_irq_in & {7'h7f, async_serial_rx}, 8'hff);
    chk(analog_chan_en[15:8] | analog_chan_en[7:0], 8'h0);
    for (int i = 0; i < 17; i++) begin
      rd(8'(i * 4));
    end
    apb(1'b0, 8'h44, 32'h0);
    cmp32({prv[30:0], erv}, 32'h1);
    for (int i = 13; i < 17; i++) begin
      wr(8'(i * 4), $urandom());
      rd(8'(i * 4));
      wr(8'(i * 4), 32'h0);
    end
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 13; i++) begin
        wr(8'(i * 4), $urandom());
      end
      {ext_a, ext_b, ext_c, ext_d, ext_e} <= 37'({$urandom(), $urandom()});
      pause();
      dr = mdl[9][7:0];
      chk(port_d_pins_oe_n, ~dr);
      chk(port_d_pins_out & dr, mdl[8][7:0] & dr);
      chk(port_a_pullup, 8'(mdl[2][7:0] & ~mdl[1][7:0]));
      chk({1'b0, port_c_pullup}, 8'(mdl[7][6:0] & ~mdl[6][6:0]));
      chk(port_d_pullup, 8'(mdl[10][7:0] & ~dr));
      chk(port_a_pins_out & mdl[1][7:0], mdl[0][7:0] & mdl[1][7:0]);
      chk(port_b_pins_out & mdl[4][7:0], mdl[3][7:0] & mdl[4][7:0]);
      chk({1'b0, port_c_pins_out & mdl[6][6:0]},
          8'(mdl[5][6:0] & mdl[6][6:0]));
      chk({1'b0, port_c_pins_oe_n}, {1'b0, ~mdl[6][6:0]});
      chk({2'b0, port_e_pins_oe_n}, {2'b0, ~mdl[12][5:0]});
      apb(1'b0, ppfm_pkg::B_DATA, 32'h0);
      dr = mdl[4][7:0];
      cmp32(prv, {24'h0, 8'(dr & mdl[3][7:0] | ~dr & ext_b)});
    end
    wr(ppfm_pkg::FUNC_A, $urandom());
    ks = mdl[13][7:0];
    an = mdl[13][15:8];
    wr(ppfm_pkg::A_DIR, {24'h0, ~ks});
    wr(ppfm_pkg::B_DIR, 32'hff);
    wr(ppfm_pkg::FUNC_B, $urandom());
    pause();
    chk(analog_chan_en[15:8], an);
    chk(analog_chan_en[7:0], mdl[14][7:0]);
    chk(port_b_pins_oe_n, mdl[14][7:0]);
    chk(port_a_pins_oe_n, ks | an);
    dr = mdl[2][7:0] & ks & ~an;
    chk(port_a_pullup, dr);
    chk(keypad_irq_in, 8'(~(ks & ~an) | dr | ext_a));
    wr(ppfm_pkg::D_DIR, 32'h0);
    wr(ppfm_pkg::FUNC_D, {22'h0, 2'b01, 8'($urandom())});
    {spi_out, spi_oe, first_timer_out, first_timer_oe, second_timer_out,
     second_timer_oe} <= 24'($urandom());
    pause();
    tm = mdl[15][7:0];
    dr = {tm[3:0] & (tm[7:4] & second_timer_oe | ~tm[7:4] & first_timer_oe),
          spi_oe};
    chk(port_d_pins_oe_n, ~dr);
    chk(port_d_pins_out & dr, dr & {tm[7:4] & second_timer_out
        | ~tm[7:4] & first_timer_out, spi_out});
    chk({second_timer_in, spi_in}, port_d_pins_in);
    chk({first_timer_in, spi_in}, port_d_pins_in);
    chk(port_d_pullup, 8'(mdl[10][7:0] & ~dr));
    wr(ppfm_pkg::FUNC_D, 32'h200);
    wr(ppfm_pkg::FUNC_E, 32'h1);
    for (int k = 0; k < 2; k++) begin
      @(posedge pclk);
      clock_out_src <= k[0];
      async_serial_tx <= ~k[0];
      ext_e <= 6'($urandom());
      pause();
      chk({6'h0, port_d_pins_oe_n[0], port_d_pins_out[0]}, {7'h0, k[0]});
      chk({4'h0, port_e_pins_oe_n[1:0], port_e_pins_out[0], async_serial_rx},
          {4'h0, 2'b10, ~k[0], ext_e[1]});
    end
    wr(ppfm_pkg::FUNC_E, 32'h0);
    pause();
    chk({7'h0, async_serial_rx}, 8'h1);
    end_of_test();
  end
endmodule
